// ---- design/cer_pkg.sv ----
/*
 Constants, codes and helpers shared by the emergency reporter.
 Assumes a single 250 MHz system clock.
*/
package cer_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned MS_NS         = 1_000_000;
	localparam int unsigned CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Frame queue shape and counter widths
	localparam int unsigned FRAME_W     = 64;
	localparam int unsigned QUEUE_DEPTH = 4;
	localparam int unsigned QPTR_W      = 2;
	localparam int unsigned ALM_CNT_W   = 8;
	localparam int unsigned LIMIT_W     = 24;

	// Emergency error codes
	localparam logic [15:0] EMCY_ALM_FIRST = 16'hff01;
	localparam logic [15:0] EMCY_ALM_OUT   = 16'hff02;
	localparam logic [15:0] EMCY_ALM_MORE  = 16'hff03;
	localparam logic [15:0] EMCY_ALL_CLEAR = 16'h0000;
	localparam logic [15:0] EMCY_CAN_OVF   = 16'h8110;
	localparam logic [15:0] EMCY_PASSIVE   = 16'h8120;
	localparam logic [15:0] EMCY_GUARD     = 16'h8130;

	// Error register values
	localparam logic [7:0] ERRREG_ALARM = 8'h81;
	localparam logic [7:0] ERRREG_CLEAR = 8'h00;
	localparam logic [7:0] ERRREG_COMM  = 8'h11;

	// Module index byte values for controller overflows
	localparam logic [7:0] MOD_RX_OVF = 8'h01;
	localparam logic [7:0] MOD_TX_OVF = 8'h02;
	localparam logic [7:0] MOD_NONE   = 8'h00;

	// Internal safety-bus error codes
	localparam logic [15:0] SB_RX_OVF    = 16'h4501;
	localparam logic [15:0] SB_PASSIVE   = 16'h4503;
	localparam logic [15:0] SB_BUS_OFF   = 16'h4504;
	localparam logic [15:0] SB_TX_OVF    = 16'h4506;
	localparam logic [15:0] SB_INIT_FAIL = 16'hc507;
	localparam logic [15:0] SB_CABLE     = 16'h4508;

	// Fault pending bit positions, lowest served first
	localparam int unsigned F_INIT     = 0;
	localparam int unsigned F_BUS_OFF  = 1;
	localparam int unsigned F_RX_OVF   = 2;
	localparam int unsigned F_TX_OVF   = 3;
	localparam int unsigned F_PASSIVE  = 4;
	localparam int unsigned F_LIFE     = 5;
	localparam int unsigned F_HBEAT    = 6;
	localparam int unsigned NUM_FAULTS = 7;

	typedef enum logic [1:0] {
		CER_ST_FREE = 2'b01,
		CER_ST_ERR  = 2'b10
	} cer_state_t;

	// Byte 0 code low, byte 1 code high, byte 2 error register, bytes 3..7 module bytes
	function automatic logic [FRAME_W-1:0] cer_frame(
		input logic [15:0] code,
		input logic [7:0]  errreg,
		input logic [7:0]  index,
		input logic [31:0] diag
	);
		cer_frame = {diag, index, errreg, code};
	endfunction : cer_frame

endpackage : cer_pkg

// ---- design/cer_frame_mem.sv ----
/*
 Small dual-port memory holding queued emergency frames.
 Read data are registered: valid one cycle after i_rd_en.
*/
`timescale 1ns/1ps
`default_nettype none

module cer_frame_mem #(
	parameter int unsigned WIDTH  = 64,
	parameter int unsigned DEPTH  = 4,
	parameter int unsigned ADDR_W = 2
) (
	input  wire logic              i_clk,
	input  wire logic              i_wr_en,
	input  wire logic [ADDR_W-1:0] i_wr_addr,
	input  wire logic [WIDTH-1:0]  i_wr_data,
	input  wire logic              i_rd_en,
	input  wire logic [ADDR_W-1:0] i_rd_addr,
	output var  logic [WIDTH-1:0]  o_rd_data
);

	logic [WIDTH-1:0] mem_r [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			mem_r[i_wr_addr] <= i_wr_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rd_en) begin
			o_rd_data <= mem_r[i_rd_addr];
		end
	end

endmodule : cer_frame_mem

`default_nettype wire

// ---- design/cer_watchdog.sv ----
/*
 Millisecond watchdog for guarding and heartbeat supervision.
 Assumes i_tick pulses once per millisecond.
*/
`timescale 1ns/1ps
`default_nettype none

module cer_watchdog #(
	parameter int unsigned LIMIT_W = 24
) (
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_tick,
	input  wire logic [LIMIT_W-1:0] i_limit,
	input  wire logic               i_kick,
	input  wire logic               i_stop,
	output var  logic               o_expire
);

	logic               armed_r;
	logic [LIMIT_W-1:0] cnt_r;
	logic               hit;

	// Armed only by a kick and disarmed again on expiry, so an idle link never expires
	assign hit = armed_r && i_tick && !i_kick && (cnt_r + LIMIT_W'(1) >= i_limit);

	always_ff @(posedge i_clk) begin
		if (!i_nrst || i_stop || i_limit == '0) begin
			armed_r <= 1'b0;
		end else if (i_kick) begin
			armed_r <= 1'b1;
		end else if (hit) begin
			armed_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst || i_kick || !armed_r) begin
			cnt_r <= '0;
		end else if (i_tick) begin
			cnt_r <= cnt_r + LIMIT_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_expire <= 1'b0;
		end else begin
			o_expire <= hit && !i_stop && i_limit != '0;
		end
	end

endmodule : cer_watchdog

`default_nettype wire

// ---- design/cer_reporter.sv ----
/*
 Emergency reporter: emergency state, fault mapping, frame queue.
 Assumes fault inputs are one-cycle pulses synchronous to i_clk and
 that the consumer holds i_emcy_ready as a plain level.
*/
`timescale 1ns/1ps
`default_nettype none

module cer_reporter
	import cer_pkg::*;
#(
	parameter int unsigned P_CYC_PER_MS = cer_pkg::CYC_PER_MS,
	parameter int unsigned P_DEPTH      = cer_pkg::QUEUE_DEPTH
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_nrst,
	// Module alarms
	input  wire logic                        i_alm_valid,
	input  wire logic                        i_alm_incoming,
	input  wire logic [7:0]                  i_module_index_byte,
	input  wire logic [31:0]                 i_module_diagnostic_bytes,
	output var  logic                        o_alm_ready,
	// Controller faults
	input  wire logic                        i_rx_overflow,
	input  wire logic                        i_err_passive,
	input  wire logic                        i_bus_off,
	input  wire logic                        i_tx_overflow,
	input  wire logic                        i_init_fail,
	// Guarding supervision
	input  wire logic [15:0]                 i_guard_time_ms,
	input  wire logic [7:0]                  i_life_factor,
	input  wire logic                        i_guard_request,
	input  wire logic [15:0]                 i_hb_consumer_ms,
	input  wire logic                        i_hb_received,
	input  wire logic                        i_reset_comm,
	// Emergency frames
	output var  logic                        o_emcy_valid,
	output var  logic [cer_pkg::FRAME_W-1:0] o_emcy_data,
	input  wire logic                        i_emcy_ready,
	// Safety-bus errors, history, status
	output var  logic                        o_sb_err_valid,
	output var  logic [15:0]                 o_sb_err_code,
	output var  logic                        o_error_history_object_valid,
	output var  logic [31:0]                 o_error_history_object_data,
	output var  logic                        o_proc_in_clear,
	output var  logic                        o_errors_present
);

	localparam int unsigned TICK_W = $clog2(P_CYC_PER_MS + 1);
	localparam logic [QPTR_W:0] DEPTH_C = (QPTR_W + 1)'(P_DEPTH);

	cer_state_t           state_r;
	cer_state_t           state_nxt;
	logic [ALM_CNT_W-1:0] alm_cnt_r;
	logic [ALM_CNT_W-1:0] alm_cnt_nxt;
	logic [NUM_FAULTS-1:0] pend_r;
	logic [NUM_FAULTS-1:0] raise;
	logic [NUM_FAULTS-1:0] served;
	logic                 buf_valid_r;
	logic                 buf_incoming_r;
	logic [7:0]           buf_index_r;
	logic [31:0]          buf_diag_r;
	logic                 accept;
	logic                 alm_take;
	logic                 go;
	logic                 push;
	logic [FRAME_W-1:0]   push_frame;
	logic                 sb_nxt;
	logic [15:0]          sb_code_nxt;
	logic                 hist_nxt;
	logic                 clr_nxt;
	logic [TICK_W-1:0]    tick_cnt_r;
	logic                 tick_r;
	logic                 life_expire;
	logic                 hb_expire;
	logic [LIMIT_W-1:0]   life_limit;
	logic [QPTR_W-1:0]    wr_ptr_r;
	logic [QPTR_W-1:0]    rd_ptr_r;
	logic [QPTR_W:0]      q_cnt_r;
	logic                 pop;
	logic                 pop_pend_r;
	logic [FRAME_W-1:0]   mem_rd_data;

	// Millisecond tick for both watchdogs
	always_ff @(posedge i_clk) begin
		if (!i_nrst || tick_r) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + TICK_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == TICK_W'(P_CYC_PER_MS - 2));
		end
	end

	assign life_limit = LIMIT_W'(i_guard_time_ms) * LIMIT_W'(i_life_factor);

	cer_watchdog #(.LIMIT_W(LIMIT_W)) u_life (
		.i_clk    (i_clk),
		.i_nrst   (i_nrst),
		.i_tick   (tick_r),
		.i_limit  (life_limit),
		.i_kick   (i_guard_request),
		.i_stop   (i_reset_comm),
		.o_expire (life_expire)
	);

	cer_watchdog #(.LIMIT_W(LIMIT_W)) u_hbeat (
		.i_clk    (i_clk),
		.i_nrst   (i_nrst),
		.i_tick   (tick_r),
		.i_limit  ({8'h00, i_hb_consumer_ms}),
		.i_kick   (i_hb_received),
		.i_stop   (i_reset_comm),
		.o_expire (hb_expire)
	);

	// Fault latches; a new pulse wins over the clear of the same bit
	always_comb begin
		raise = '0;
		raise[F_INIT]    = i_init_fail;
		raise[F_BUS_OFF] = i_bus_off;
		raise[F_RX_OVF]  = i_rx_overflow;
		raise[F_TX_OVF]  = i_tx_overflow;
		raise[F_PASSIVE] = i_err_passive;
		raise[F_LIFE]    = life_expire;
		raise[F_HBEAT]   = hb_expire;
	end

	// Events stall while the queue is full rather than drop frames
	assign go       = (q_cnt_r != DEPTH_C);
	assign served   = go ? (pend_r & (~pend_r + NUM_FAULTS'(1))) : '0;
	assign alm_take = go && (pend_r == '0) && buf_valid_r;
	assign accept   = i_alm_valid && o_alm_ready;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			pend_r <= '0;
		end else begin
			pend_r <= (pend_r & ~served) | raise;
		end
	end

	// One-entry alarm holding stage keeps o_alm_ready registered
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			buf_valid_r <= 1'b0;
			o_alm_ready <= 1'b0;
		end else begin
			buf_valid_r <= (buf_valid_r && !alm_take) || accept;
			o_alm_ready <= !((buf_valid_r && !alm_take) || accept);
		end
	end

	always_ff @(posedge i_clk) begin
		if (accept) begin
			buf_incoming_r <= i_alm_incoming;
			buf_index_r    <= i_module_index_byte;
			buf_diag_r     <= i_module_diagnostic_bytes;
		end
	end

	// Event decode: one fault or one alarm per cycle
	always_comb begin
		state_nxt   = state_r;
		alm_cnt_nxt = alm_cnt_r;
		push        = 1'b0;
		push_frame  = '0;
		sb_nxt      = 1'b0;
		sb_code_nxt = '0;
		hist_nxt    = 1'b0;
		clr_nxt     = 1'b0;
		if (served[F_INIT]) begin
			sb_nxt      = 1'b1;
			sb_code_nxt = SB_INIT_FAIL;
		end else if (served[F_BUS_OFF]) begin
			sb_nxt      = 1'b1;
			sb_code_nxt = SB_BUS_OFF;
		end else if (served[F_RX_OVF]) begin
			sb_nxt      = 1'b1;
			sb_code_nxt = SB_RX_OVF;
			push        = 1'b1;
			push_frame  = cer_frame(EMCY_CAN_OVF, ERRREG_COMM, MOD_RX_OVF, '0);
		end else if (served[F_TX_OVF]) begin
			sb_nxt      = 1'b1;
			sb_code_nxt = SB_TX_OVF;
			push        = 1'b1;
			push_frame  = cer_frame(EMCY_CAN_OVF, ERRREG_COMM, MOD_TX_OVF, '0);
		end else if (served[F_PASSIVE]) begin
			sb_nxt      = 1'b1;
			sb_code_nxt = SB_PASSIVE;
			push        = 1'b1;
			push_frame  = cer_frame(EMCY_PASSIVE, ERRREG_COMM, MOD_NONE, '0);
		end else if (served[F_LIFE] || served[F_HBEAT]) begin
			sb_nxt      = 1'b1;
			sb_code_nxt = SB_CABLE;
			push        = 1'b1;
			push_frame  = cer_frame(EMCY_GUARD, ERRREG_COMM, MOD_NONE, '0);
			clr_nxt     = served[F_HBEAT];
		end else if (alm_take) begin
			if (buf_incoming_r) begin
				push      = 1'b1;
				hist_nxt  = 1'b1;
				state_nxt = CER_ST_ERR;
				if (alm_cnt_r != '1) begin
					alm_cnt_nxt = alm_cnt_r + ALM_CNT_W'(1);
				end
				if (alm_cnt_r == '0) begin
					push_frame = cer_frame(EMCY_ALM_FIRST, ERRREG_ALARM, buf_index_r,
						buf_diag_r);
				end else begin
					push_frame = cer_frame(EMCY_ALM_MORE, ERRREG_ALARM, buf_index_r,
						buf_diag_r);
				end
			end else if (alm_cnt_r > 8'h01) begin
				push        = 1'b1;
				hist_nxt    = 1'b1;
				alm_cnt_nxt = alm_cnt_r - ALM_CNT_W'(1);
				push_frame  = cer_frame(EMCY_ALM_OUT, ERRREG_ALARM, buf_index_r, buf_diag_r);
			end else if (alm_cnt_r == 8'h01) begin
				push        = 1'b1;
				alm_cnt_nxt = '0;
				state_nxt   = CER_ST_FREE;
				push_frame  = cer_frame(EMCY_ALL_CLEAR, ERRREG_CLEAR, MOD_NONE, '0);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state_r   <= CER_ST_FREE;
			alm_cnt_r <= '0;
		end else begin
			state_r   <= state_nxt;
			alm_cnt_r <= alm_cnt_nxt;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_sb_err_valid               <= 1'b0;
			o_sb_err_code                <= '0;
			o_error_history_object_valid <= 1'b0;
			o_error_history_object_data  <= '0;
			o_proc_in_clear              <= 1'b0;
			o_errors_present             <= 1'b0;
		end else begin
			o_sb_err_valid               <= sb_nxt;
			o_sb_err_code                <= sb_code_nxt;
			o_error_history_object_valid <= hist_nxt;
			o_error_history_object_data  <= hist_nxt ? buf_diag_r : '0;
			o_proc_in_clear              <= clr_nxt;
			o_errors_present             <= (state_nxt == CER_ST_ERR);
		end
	end

	// Frame queue; pop needs one cycle for the registered memory read
	assign pop = (q_cnt_r != '0) && !pop_pend_r && (!o_emcy_valid || i_emcy_ready);

	cer_frame_mem #(
		.WIDTH  (FRAME_W),
		.DEPTH  (P_DEPTH),
		.ADDR_W (QPTR_W)
	) u_mem (
		.i_clk     (i_clk),
		.i_wr_en   (push),
		.i_wr_addr (wr_ptr_r),
		.i_wr_data (push_frame),
		.i_rd_en   (pop),
		.i_rd_addr (rd_ptr_r),
		.o_rd_data (mem_rd_data)
	);

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			q_cnt_r    <= '0;
			pop_pend_r <= 1'b0;
		end else begin
			wr_ptr_r   <= wr_ptr_r + QPTR_W'(push);
			rd_ptr_r   <= rd_ptr_r + QPTR_W'(pop);
			q_cnt_r    <= q_cnt_r + (QPTR_W + 1)'(push) - (QPTR_W + 1)'(pop);
			pop_pend_r <= pop;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_emcy_valid <= 1'b0;
			o_emcy_data  <= '0;
		end else if (pop_pend_r) begin
			o_emcy_valid <= 1'b1;
			o_emcy_data  <= mem_rd_data;
		end else if (i_emcy_ready) begin
			o_emcy_valid <= 1'b0;
		end
	end

endmodule : cer_reporter

`default_nettype wire

// ---- verification/cer_reporter_assertions.sv ----
/*
 Port checker for the emergency reporter, bound to cer_reporter.
 Assumes one clock domain with the synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cer_reporter_checker (
	input wire logic                        i_clk,
	input wire logic                        i_nrst,
	input wire logic                        i_emcy_ready,
	input wire logic                        o_emcy_valid,
	input wire logic [cer_pkg::FRAME_W-1:0] o_emcy_data,
	input wire logic                        o_sb_err_valid,
	input wire logic [15:0]                 o_sb_err_code,
	input wire logic                        o_error_history_object_valid,
	input wire logic                        o_errors_present
);
	logic [15:0] code;
	assign code = o_emcy_data[15:0];
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	AST_FRAME_HOLD: assert property (o_emcy_valid && !i_emcy_ready |=>
		o_emcy_valid && $stable(o_emcy_data)) else $error("frame changed before accept");
	AST_SB_CODES: assert property (o_sb_err_valid |-> o_sb_err_code inside
		{16'h4501, 16'h4503, 16'h4504, 16'h4506, 16'hc507, 16'h4508})
		else $error("bad safety-bus code");
	AST_FRAME_CODES: assert property (o_emcy_valid |-> code inside {16'hff01,
		16'hff02, 16'hff03, 16'h0000, 16'h8110, 16'h8120, 16'h8130})
		else $error("bad emergency code");
	AST_ALARM_REG: assert property (o_emcy_valid && code[15:8] == 8'hff |->
		o_emcy_data[23:16] == 8'h81) else $error("alarm error register wrong");
	AST_ALL_CLEAR: assert property (o_emcy_valid && code == 16'h0000 |->
		o_emcy_data == 64'h0000_0000_0000_0000) else $error("clear frame not zero");
	AST_COMM_REG: assert property (o_emcy_valid && code[15:8] == 8'h81 |->
		o_emcy_data[23:16] == 8'h11) else $error("comm error register wrong");
	AST_OVF_BYTES: assert property (o_emcy_valid && code == 16'h8110 |->
		o_emcy_data[63:24] inside {40'h00_0000_0001, 40'h00_0000_0002})
		else $error("overflow module bytes wrong");
	AST_ZERO_BYTES: assert property (o_emcy_valid && code inside {16'h8120, 16'h8130}
		|-> o_emcy_data[63:24] == 40'h00_0000_0000) else $error("module bytes not zero");
	AST_FIRST_HIST: assert property ($rose(o_errors_present) |->
		o_error_history_object_valid) else $error("first error not in history");
	AST_LAST_NOHIST: assert property ($fell(o_errors_present) |->
		!o_error_history_object_valid) else $error("all clear logged in history");
endmodule : cer_reporter_checker
bind cer_reporter cer_reporter_checker u_cer_reporter_checker (.i_clk, .i_nrst, .i_emcy_ready,
	.o_emcy_valid, .o_emcy_data, .o_sb_err_valid, .o_sb_err_code,
	.o_error_history_object_valid, .o_errors_present);
`default_nettype wire

// ---- verification/cer_consumer_model.sv ----
/*
 Emergency consumer model: accepts frames and keeps them in order.
 Assumes the bench seeds the random generator before any stall mode.
*/
`timescale 1ns/1ps
`default_nettype none
module cer_consumer_model (
	input  wire logic        i_clk,
	input  wire logic [1:0]  i_mode,
	input  wire logic        i_valid,
	input  wire logic [63:0] i_data,
	output var  logic        o_ready
);
	logic [63:0] frames[$];
	initial o_ready = 1'b1;
	// Mode 0 prompt, 1 random stalls, 2 full stall
	always @(negedge i_clk) begin
		o_ready <= (i_mode == 2'd0) ? 1'b1 : (i_mode == 2'd1) ? 1'($urandom_range(0, 1)) : 1'b0;
	end
	// Sampled on the same edge as the handshake, so no frame is double counted
	always @(posedge i_clk) begin
		if (i_valid === 1'b1 && o_ready === 1'b1) frames.push_back(i_data);
	end
endmodule : cer_consumer_model
`default_nettype wire

// ---- verification/cer_reporter_tb_top.sv ----
/*
 Self-checking bench for cer_reporter with a consumer model.
 Assumes a shortened millisecond of 10 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module cer_reporter_tb_top;
	import cer_pkg::*;
	localparam int CPM = 10;
	logic        i_clk = 0, i_nrst = 0, av = 0, ainc = 0;
	logic [7:0]  aidx = 0, lf = 0, pl = 0;
	logic [31:0] adiag = 0, hd;
	logic [15:0] gt = 0, hbt = 0, sbc;
	logic [1:0]  mode = 0;
	logic        ardy, ev, rdy, sbv, hv, pic, ep;
	logic [63:0] ed;
	logic [15:0] sbq[$];
	logic [31:0] hq[$];
	int          pcc, n_errors, compares;
	always #2 i_clk = ~i_clk;
	cer_reporter #(.P_CYC_PER_MS(CPM)) u_cer_reporter (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_alm_valid(av), .i_alm_incoming(ainc), .i_module_index_byte(aidx),
		.i_module_diagnostic_bytes(adiag), .o_alm_ready(ardy), .i_rx_overflow(pl[0]),
		.i_err_passive(pl[1]), .i_bus_off(pl[2]), .i_tx_overflow(pl[3]), .i_init_fail(pl[4]),
		.i_guard_time_ms(gt), .i_life_factor(lf), .i_guard_request(pl[5]),
		.i_hb_consumer_ms(hbt), .i_hb_received(pl[6]), .i_reset_comm(pl[7]),
		.o_emcy_valid(ev), .o_emcy_data(ed), .i_emcy_ready(rdy), .o_sb_err_valid(sbv),
		.o_sb_err_code(sbc), .o_error_history_object_valid(hv),
		.o_error_history_object_data(hd), .o_proc_in_clear(pic), .o_errors_present(ep));
	cer_consumer_model u_cer_consumer_model (.i_clk(i_clk), .i_mode(mode), .i_valid(ev),
		.i_data(ed), .o_ready(rdy));
	always @(posedge i_clk) begin
		if (sbv === 1'b1) sbq.push_back(sbc);
		if (hv === 1'b1) hq.push_back(hd);
		if (pic === 1'b1) pcc++;
	end
	task chk(string nm, logic [63:0] seen, logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task complete_run;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	function automatic logic [63:0] fr(logic [15:0] c, logic [7:0] r, logic [7:0] m,
		logic [31:0] d);
		return {d, m, r, c};
	endfunction : fr
	function automatic logic [63:0] alarm_frame(bit inc, int cnt, logic [7:0] m, logic [31:0] d);
		if (inc) return fr((cnt == 0) ? 16'hff01 : 16'hff03, 8'h81, m, d);
		if (cnt == 1) return 64'h0000_0000_0000_0000;
		return fr(16'hff02, 8'h81, m, d);
	endfunction : alarm_frame
	task settle(int n);
		repeat (n) @(negedge i_clk);
	endtask : settle
	// Generous wait covers random consumer stalls and the queue pipeline
	task expect_ev(bit hf, logic [63:0] f, bit hs, logic [15:0] s, bit hh, logic [31:0] h);
		settle(60);
		chk("frame count", u_cer_consumer_model.frames.size(), hf);
		if (hf) chk("frame", u_cer_consumer_model.frames.pop_front(), f);
		chk("sb count", sbq.size(), hs);
		if (hs) chk("sb code", sbq.pop_front(), s);
		chk("history count", hq.size(), hh);
		if (hh) chk("history", hq.pop_front(), h);
	endtask : expect_ev
	task alarm(bit inc, logic [7:0] m, logic [31:0] d);
		int k;
		av = 1'b1;
		ainc = inc;
		aidx = m;
		adiag = d;
		for (k = 0; k < 50 && ardy !== 1'b1; k++) @(negedge i_clk);
		if (k == 50) begin
			n_errors++;
			complete_run;
		end
		@(negedge i_clk);
		av = 1'b0;
	endtask : alarm
	task pulse(logic [7:0] m);
		pl = m;
		@(negedge i_clk);
		pl = 8'h00;
	endtask : pulse
	initial begin
		logic [63:0] fx[5];
		logic [15:0] sx[5];
		int          cnt;
		bit          inc;
		logic [7:0]  ix;
		logic [31:0] dx;
		void'($urandom(32'h130f));
		settle(8);
		chk("reset valid", ev, 0);
		chk("reset present", ep, 0);
		i_nrst = 1'b1;
		settle(2);
		fx = '{fr(16'h8110, 8'h11, 8'h01, 0), fr(16'h8120, 8'h11, 0, 0), 0,
			fr(16'h8110, 8'h11, 8'h02, 0), 0};
		sx = '{16'h4501, 16'h4503, 16'h4504, 16'h4506, 16'hc507};
		for (int i = 0; i < 5; i++) begin
			pulse(8'h01 << i);
			expect_ev(fx[i] != 0, fx[i], 1, sx[i], 0, 0);
		end
		$display("test faults done");
		mode = 2'd2;
		pulse(8'h09);
		settle(20);
		chk("stalled frames", u_cer_consumer_model.frames.size(), 0);
		mode = 2'd0;
		// Both stalled frames arrive in one window; both codes were already logged during the stall
		settle(60);
		chk("order count", u_cer_consumer_model.frames.size(), 2);
		chk("first frame", u_cer_consumer_model.frames.pop_front(), fx[0]);
		chk("second frame", u_cer_consumer_model.frames.pop_front(), fx[3]);
		chk("order sb count", sbq.size(), 2);
		chk("first sb", sbq.pop_front(), 16'h4501);
		chk("second sb", sbq.pop_front(), 16'h4506);
		chk("order history", hq.size(), 0);
		$display("test order done");
		mode = 2'd1;
		alarm(0, 8'h05, 32'h1234_5678);
		expect_ev(0, 0, 0, 0, 0, 0);
		cnt = 0;
		for (int i = 0; i < 30 || cnt > 0; i++) begin
			inc = (i < 30) && (cnt == 0 || $urandom_range(0, 1) == 1);
			ix = 8'($urandom);
			dx = $urandom;
			alarm(inc, ix, dx);
			expect_ev(1, alarm_frame(inc, cnt, ix, dx), 0, 0, !(cnt == 1 && !inc), dx);
			cnt = inc ? cnt + 1 : cnt - 1;
			chk("errors present", ep, cnt != 0);
		end
		$display("test alarms done");
		mode = 2'd0;
		gt = 16'h0001;
		lf = 8'h02;
		pulse(8'h20);
		settle(12);
		chk("early expiry", sbq.size(), 0);
		expect_ev(1, fr(16'h8130, 8'h11, 0, 0), 1, 16'h4508, 0, 0);
		pulse(8'h20);
		settle(5);
		pulse(8'h80);
		expect_ev(0, 0, 0, 0, 0, 0);
		gt = 16'h0000;
		hbt = 16'h0003;
		pulse(8'h40);
		expect_ev(1, fr(16'h8130, 8'h11, 0, 0), 1, 16'h4508, 0, 0);
		chk("process clear", pcc, 1);
		$display("test guarding done");
		complete_run;
	end
endmodule : cer_reporter_tb_top
`default_nettype wire
